// >>> src/tap_regs.svh
// Register offsets, field layouts, reset values and sizes of the address-pattern block
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

// ***********************************************************
// Address geometry
// ***********************************************************
`define TAP_WADDR_W 26
`define TAP_SYM_SHIFT 5
`define TAP_SADDR_W 31
`define TAP_NUM_FIELDS 6
`define TAP_NUM_MSB 5
`define TAP_TOP_MSB 6'h19
`define TAP_PERIOD_W 16
`define TAP_MSB_W 6
`define TAP_BURST_W 8
`define TAP_RES_W 4
`define TAP_ST_W 2

// ***********************************************************
// APB register map (byte addresses)
// ***********************************************************
`define TAP_PADDR_W 12
`define TAP_CTRL_OFS 12'h000
`define TAP_BURST_OFS 12'h004
`define TAP_STATUS_OFS 12'h008
`define TAP_MASK_OFS 12'h00C
`define TAP_ADDR_OFS 12'h010
`define TAP_MODE_BASE 12'h020
`define TAP_WSTART_BASE 12'h040
`define TAP_RSTART_BASE 12'h060
`define TAP_INCR_BASE 12'h080
`define TAP_PERIOD_BASE 12'h0A0
`define TAP_MSB_BASE 12'h0C0
`define TAP_GRP_LSB 5
`define TAP_IDX_MSB 4
`define TAP_IDX_LSB 2

// ***********************************************************
// Bit positions and reset values
// ***********************************************************
`define TAP_CTRL_RESTART_BIT 0
`define TAP_CTRL_HALFRATE_BIT 1
`define TAP_CTRL_RELOAD_BIT 2
`define TAP_ST_WIDTH_ERR_BIT 0
`define TAP_ST_ADDR_BIT 1
`define TAP_BURST_RST 8'h01
`define TAP_PERIOD_RST 16'h0001
`define TAP_MSB_RST 6'h19

`endif

// >>> src/tap_pkg.sv
// Types shared by the address-pattern block and its field generators
`default_nettype none
`include "tap_regs.svh"

package tap_pkg;

	// Generator modes
	typedef enum logic [1:0] {
		TAP_FIXED = 2'h0,
		TAP_RANDOM = 2'h1,
		TAP_SEQ = 2'h2,
		TAP_UNUSED = 2'h3
	} tap_mode_t;

	// State of one field generator
	typedef struct packed {
		logic [`TAP_WADDR_W-1:0] value;
		logic [`TAP_PERIOD_W-1:0] count;
	} tap_gen_state_t;

	// State of the top module
	typedef struct packed {
		tap_mode_t [`TAP_NUM_FIELDS-1:0] mode;
		logic [`TAP_NUM_FIELDS-1:0][`TAP_WADDR_W-1:0] wstart;
		logic [`TAP_NUM_FIELDS-1:0][`TAP_WADDR_W-1:0] rstart;
		logic [`TAP_NUM_FIELDS-1:0][`TAP_WADDR_W-1:0] incr;
		logic [`TAP_NUM_FIELDS-1:0][`TAP_PERIOD_W-1:0] period;
		logic [`TAP_NUM_MSB-1:0][`TAP_MSB_W-1:0] msb;
		logic restart_en;
		logic half_rate;
		logic [`TAP_BURST_W-1:0] burst;
		logic [`TAP_ST_W-1:0] status;
		logic [`TAP_ST_W-1:0] mask;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [`TAP_WADDR_W-1:0] word_addr;
		logic [`TAP_SADDR_W-1:0] symbol_addr;
		logic addr_valid;
		logic addr_is_read;
	} tap_state_t;

endpackage : tap_pkg
`default_nettype wire

// >>> src/tap_field_gen.sv
// One address field generator: fixed, random, sequential or unused
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"

module tap_field_gen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire tap_pkg::tap_mode_t mode,
	input wire logic [`TAP_WADDR_W-1:0] start_value,
	input wire logic [`TAP_WADDR_W-1:0] step_value,
	input wire logic [`TAP_PERIOD_W-1:0] period,
	input wire logic [`TAP_WADDR_W-1:0] width_mask,
	input wire logic [`TAP_MSB_W-1:0] width,
	input wire logic load,
	input wire logic step,
	output logic [`TAP_WADDR_W-1:0] value
);

	tap_pkg::tap_gen_state_t s_reg;
	tap_pkg::tap_gen_state_t s_next;
	logic feedback;

	// Maximal-length taps per field width; all-ones is the lockup state
	function automatic logic [`TAP_WADDR_W-1:0] taps(input logic [`TAP_MSB_W-1:0] w);
		case (w)
			6'h01: taps = 26'h0000001;
			6'h02: taps = 26'h0000003;
			6'h03: taps = 26'h0000006;
			6'h04: taps = 26'h000000C;
			6'h05: taps = 26'h0000014;
			6'h06: taps = 26'h0000030;
			6'h07: taps = 26'h0000060;
			6'h08: taps = 26'h00000B8;
			6'h09: taps = 26'h0000110;
			6'h0A: taps = 26'h0000240;
			6'h0B: taps = 26'h0000500;
			6'h0C: taps = 26'h0000829;
			6'h0D: taps = 26'h000100D;
			6'h0E: taps = 26'h0002015;
			6'h0F: taps = 26'h0006000;
			6'h10: taps = 26'h000D008;
			6'h11: taps = 26'h0012000;
			6'h12: taps = 26'h0020400;
			6'h13: taps = 26'h0040023;
			6'h14: taps = 26'h0090000;
			6'h15: taps = 26'h0140000;
			6'h16: taps = 26'h0300000;
			6'h17: taps = 26'h0420000;
			6'h18: taps = 26'h0E10000;
			6'h19: taps = 26'h1200000;
			6'h1A: taps = 26'h2000023;
			default: taps = '0;
		endcase
	endfunction : taps

	// Next value on load or on every k-th operation
	always_comb begin
		s_next = s_reg;
		feedback = ~^(s_reg.value & taps(width));
		if (load) begin
			s_next.value = start_value & width_mask;
			s_next.count = '0;
		end else if (step) begin
			if (({1'b0, s_reg.count} + 17'h00001) >= {1'b0, period}) begin
				s_next.count = '0;
				case (mode)
					tap_pkg::TAP_RANDOM: begin
						s_next.value = ({s_reg.value[`TAP_WADDR_W-2:0], feedback}) & width_mask;
					end
					tap_pkg::TAP_SEQ: begin
						s_next.value = (s_reg.value + step_value) & width_mask;
					end
					default: begin
						s_next.value = s_reg.value;
					end
				endcase
			end else begin
				s_next.count = s_reg.count + 16'h0001;
			end
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	// Field output, right-aligned
	always_comb begin
		case (mode)
			tap_pkg::TAP_FIXED: value = start_value & width_mask;
			tap_pkg::TAP_UNUSED: value = '0;
			default: value = s_reg.value & width_mask;
		endcase
	end

endmodule : tap_field_gen
`default_nettype wire

// >>> src/tap_addr_pattern.sv
// Address-pattern generator of the memory traffic generator, with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"

module tap_addr_pattern (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`TAP_PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic wr_issue,
	input wire logic rd_issue,
	input wire logic loop_start,
	output logic [`TAP_WADDR_W-1:0] word_addr,
	output logic [`TAP_SADDR_W-1:0] symbol_addr,
	output logic addr_valid,
	output logic addr_is_read,
	output logic irq
);

	tap_pkg::tap_state_t s_reg;
	tap_pkg::tap_state_t s_next;

	// ***********************************************************
	// Register map
	// ***********************************************************
	// Control: loop restart enable, half-rate alignment, reload pulse
	// Burst: configured burst length; zero counts as one
	// Status: sticky events, write one to clear; a new event wins
	// Mask: interrupt enable per status bit
	// Address: last issued word address, read only
	// Per field n, one word apart: mode, write start, read start,
	// increment, update period, and top index for fields 0 to 4
	// Unaligned or unmapped accesses get an error and change nothing

	// ***********************************************************
	// Field geometry
	// ***********************************************************
	logic [`TAP_NUM_FIELDS-1:0][`TAP_MSB_W-1:0] field_top_bit_index;
	logic [`TAP_NUM_FIELDS-1:0][`TAP_MSB_W-1:0] field_lo;
	logic [`TAP_NUM_FIELDS-1:0][`TAP_MSB_W-1:0] field_width;
	logic [`TAP_NUM_FIELDS-1:0][`TAP_WADDR_W-1:0] field_mask;
	logic [`TAP_NUM_FIELDS-1:0][`TAP_WADDR_W-1:0] wr_val;
	logic [`TAP_NUM_FIELDS-1:0][`TAP_WADDR_W-1:0] rd_val;
	logic [`TAP_RES_W-1:0] reserved_bits;
	logic [`TAP_WADDR_W-1:0] reserved_mask;
	logic [`TAP_WADDR_W-1:0] wr_addr;
	logic [`TAP_WADDR_W-1:0] rd_addr;
	logic width_error;
	logic gen_load;
	logic wr_step;
	logic rd_step;

	// Ceiling of log2 for burst lengths that are not powers of two
	// A length of one, or zero, reserves no bits; three reserves two
	function automatic logic [`TAP_RES_W-1:0] ceil_log2(input logic [`TAP_BURST_W-1:0] b);
		logic [`TAP_RES_W-1:0] r;
		r = '0;
		for (int i = 0; i < `TAP_BURST_W; i++) begin
			if ((9'h001 << i) < {1'b0, b}) begin
				r = `TAP_RES_W'(i + 1);
			end
		end
		return r;
	endfunction : ceil_log2

	// Bounds of each field; a non-increasing index gives an empty field
	// Field n starts just above the top index of field n-1, so an empty
	// field can leave the next one overlapping field 0; overlapping bits
	// are ORed. The top field always ends at the top word-address bit.
	always_comb begin
		for (int n = 0; n < `TAP_NUM_FIELDS; n++) begin
			if (n == `TAP_NUM_FIELDS - 1) begin
				field_top_bit_index[n] = `TAP_TOP_MSB;
			end else begin
				field_top_bit_index[n] = s_reg.msb[n];
			end
		end
		for (int n = 0; n < `TAP_NUM_FIELDS; n++) begin
			if (n == 0) begin
				field_lo[n] = '0;
			end else begin
				field_lo[n] = field_top_bit_index[n-1] + 6'h01;
			end
			if (field_top_bit_index[n] >= field_lo[n]) begin
				field_width[n] = field_top_bit_index[n] - field_lo[n] + 6'h01;
			end else begin
				field_width[n] = '0;
			end
			field_mask[n] = `TAP_WADDR_W'((27'h0000001 << field_width[n]) - 27'h0000001);
		end
	end

	// Low bits taken by word alignment and burst length
	// Half rate reserves one more bit so the word address stays even
	// for the controller
	always_comb begin
		reserved_bits = ceil_log2(s_reg.burst) + {3'h0, s_reg.half_rate};
		reserved_mask = `TAP_WADDR_W'((27'h0000001 << reserved_bits) - 27'h0000001);
		width_error = field_width[0] < {2'h0, reserved_bits};
	end

	// Merge the six fields and clear the reserved bits
	always_comb begin
		wr_addr = '0;
		rd_addr = '0;
		for (int n = 0; n < `TAP_NUM_FIELDS; n++) begin
			wr_addr = wr_addr | `TAP_WADDR_W'(wr_val[n] << field_lo[n]);
			rd_addr = rd_addr | `TAP_WADDR_W'(rd_val[n] << field_lo[n]);
		end
		wr_addr = wr_addr & ~reserved_mask;
		rd_addr = rd_addr & ~reserved_mask;
	end

	// ***********************************************************
	// Generators
	// ***********************************************************
	// A read and a write in one cycle: the write goes out, the read is dropped
	assign wr_step = wr_issue;
	assign rd_step = rd_issue & ~wr_issue;

	// Reload on a loop start when enabled, or on a software reload
	// A reload in the cycle of an issue wins for the generators, while the
	// issue still takes the address from the values before the reload
	assign gen_load = (loop_start & s_reg.restart_en) |
		(psel & penable & s_reg.pready & pwrite &
		(paddr == `TAP_CTRL_OFS) & pwdata[`TAP_CTRL_RELOAD_BIT]);

	// Reads run their own copy of the sequence, so each read replays its write
	// Twelve generators cost area, but no address store is needed: a read
	// set replays its write set whenever the write and read starts match
	genvar g;
	generate
		for (g = 0; g < `TAP_NUM_FIELDS; g++) begin : gen_field
			tap_field_gen u_wr (
				.pclk(pclk),
				.presetn(presetn),
				.clk_en(clk_en),
				.mode(s_reg.mode[g]),
				.start_value(s_reg.wstart[g]),
				.step_value(s_reg.incr[g]),
				.period(s_reg.period[g]),
				.width_mask(field_mask[g]),
				.width(field_width[g]),
				.load(gen_load),
				.step(wr_step),
				.value(wr_val[g])
			);
			tap_field_gen u_rd (
				.pclk(pclk),
				.presetn(presetn),
				.clk_en(clk_en),
				.mode(s_reg.mode[g]),
				.start_value(s_reg.rstart[g]),
				.step_value(s_reg.incr[g]),
				.period(s_reg.period[g]),
				.width_mask(field_mask[g]),
				.width(field_width[g]),
				.load(gen_load),
				.step(rd_step),
				.value(rd_val[g])
			);
		end
	endgenerate

	// ***********************************************************
	// APB decode
	// ***********************************************************
	logic apb_setup;
	logic apb_done;
	logic [`TAP_IDX_MSB-`TAP_IDX_LSB:0] idx;
	logic in_fields;
	logic in_msbs;
	logic hit;
	logic [31:0] rd_data;
	logic [`TAP_ST_W-1:0] st_set;

	// Group match on the upper address bits
	// Both the group match and the exact compares refuse nonzero low bits
	function automatic logic grp(input logic [`TAP_PADDR_W-1:0] a,
		input logic [`TAP_PADDR_W-1:0] base);
		return (a[`TAP_PADDR_W-1:`TAP_GRP_LSB] == base[`TAP_PADDR_W-1:`TAP_GRP_LSB]) &&
			(a[`TAP_IDX_LSB-1:0] == 2'h0);
	endfunction : grp

	// Access phase is answered one cycle after it opens
	always_comb begin
		apb_setup = psel & penable & ~s_reg.pready;
		apb_done = psel & penable & s_reg.pready;
		idx = paddr[`TAP_IDX_MSB:`TAP_IDX_LSB];
		in_fields = idx < 3'(`TAP_NUM_FIELDS);
		in_msbs = idx < 3'(`TAP_NUM_MSB);
	end

	// Read mux and address check
	always_comb begin
		rd_data = '0;
		hit = 1'b1;
		if (paddr == `TAP_CTRL_OFS) begin
			rd_data[`TAP_CTRL_RESTART_BIT] = s_reg.restart_en;
			rd_data[`TAP_CTRL_HALFRATE_BIT] = s_reg.half_rate;
		end else if (paddr == `TAP_BURST_OFS) begin
			rd_data[`TAP_BURST_W-1:0] = s_reg.burst;
		end else if (paddr == `TAP_STATUS_OFS) begin
			rd_data[`TAP_ST_W-1:0] = s_reg.status;
		end else if (paddr == `TAP_MASK_OFS) begin
			rd_data[`TAP_ST_W-1:0] = s_reg.mask;
		end else if (paddr == `TAP_ADDR_OFS) begin
			rd_data[`TAP_WADDR_W-1:0] = s_reg.word_addr;
		end else if (grp(paddr, `TAP_MODE_BASE) && in_fields) begin
			rd_data[1:0] = s_reg.mode[idx];
		end else if (grp(paddr, `TAP_WSTART_BASE) && in_fields) begin
			rd_data[`TAP_WADDR_W-1:0] = s_reg.wstart[idx];
		end else if (grp(paddr, `TAP_RSTART_BASE) && in_fields) begin
			rd_data[`TAP_WADDR_W-1:0] = s_reg.rstart[idx];
		end else if (grp(paddr, `TAP_INCR_BASE) && in_fields) begin
			rd_data[`TAP_WADDR_W-1:0] = s_reg.incr[idx];
		end else if (grp(paddr, `TAP_PERIOD_BASE) && in_fields) begin
			rd_data[`TAP_PERIOD_W-1:0] = s_reg.period[idx];
		end else if (grp(paddr, `TAP_MSB_BASE) && in_msbs) begin
			rd_data[`TAP_MSB_W-1:0] = s_reg.msb[idx];
		end else begin
			hit = 1'b0;
		end
	end

	// ***********************************************************
	// Next state
	// ***********************************************************
	always_comb begin
		s_next = s_reg;
		st_set = '0;
		s_next.addr_valid = 1'b0;

		// APB handshake; data and error are registered with pready
		// One wait state always: pready rises the cycle after access opens
		s_next.pready = apb_setup;
		if (apb_setup) begin
			s_next.prdata = pwrite ? 32'h00000000 : rd_data;
			s_next.pslverr = ~hit;
		end else if (apb_done) begin
			s_next.pslverr = 1'b0;
		end

		// Register writes take effect at the completing edge
		if (apb_done && pwrite && hit) begin
			if (paddr == `TAP_CTRL_OFS) begin
				s_next.restart_en = pwdata[`TAP_CTRL_RESTART_BIT];
				s_next.half_rate = pwdata[`TAP_CTRL_HALFRATE_BIT];
			end else if (paddr == `TAP_BURST_OFS) begin
				s_next.burst = pwdata[`TAP_BURST_W-1:0];
			end else if (paddr == `TAP_MASK_OFS) begin
				s_next.mask = pwdata[`TAP_ST_W-1:0];
			end else if (grp(paddr, `TAP_MODE_BASE)) begin
				s_next.mode[idx] = tap_pkg::tap_mode_t'(pwdata[1:0]);
			end else if (grp(paddr, `TAP_WSTART_BASE)) begin
				s_next.wstart[idx] = pwdata[`TAP_WADDR_W-1:0];
			end else if (grp(paddr, `TAP_RSTART_BASE)) begin
				s_next.rstart[idx] = pwdata[`TAP_WADDR_W-1:0];
			end else if (grp(paddr, `TAP_INCR_BASE)) begin
				s_next.incr[idx] = pwdata[`TAP_WADDR_W-1:0];
			end else if (grp(paddr, `TAP_PERIOD_BASE)) begin
				s_next.period[idx] = pwdata[`TAP_PERIOD_W-1:0];
			end else if (grp(paddr, `TAP_MSB_BASE)) begin
				s_next.msb[idx] = pwdata[`TAP_MSB_W-1:0];
			end
		end

		// Issue the current address; the generators step on the same edge
		// A read in the cycle of a write is dropped and its generators hold
		if (wr_step || rd_step) begin
			s_next.word_addr = wr_step ? wr_addr : rd_addr;
			s_next.symbol_addr = {s_next.word_addr, {`TAP_SYM_SHIFT{1'b0}}};
			s_next.addr_valid = 1'b1;
			s_next.addr_is_read = rd_step;
			st_set[`TAP_ST_ADDR_BIT] = 1'b1;
			st_set[`TAP_ST_WIDTH_ERR_BIT] = width_error;
		end

		// Write-one-to-clear; an event in the same cycle keeps its bit
		if (apb_done && pwrite && (paddr == `TAP_STATUS_OFS)) begin
			s_next.status = s_reg.status & ~pwdata[`TAP_ST_W-1:0];
		end
		s_next.status = s_next.status | st_set;
		s_next.irq = |(s_next.status & s_next.mask);
	end

	// ***********************************************************
	// State register
	// ***********************************************************
	// Everything holds while the clock enable is low
	// Reset leaves burst one, every update period one and every top index
	// at the top word-address bit, so field 0 alone spans the address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.burst <= `TAP_BURST_RST;
			s_reg.period <= {`TAP_NUM_FIELDS{`TAP_PERIOD_RST}};
			s_reg.msb <= {`TAP_NUM_MSB{`TAP_MSB_RST}};
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register
	// Registered outputs keep glitches off the controller's command port
	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign word_addr = s_reg.word_addr;
	assign symbol_addr = s_reg.symbol_addr;
	assign addr_valid = s_reg.addr_valid;
	assign addr_is_read = s_reg.addr_is_read;
	assign irq = s_reg.irq;

endmodule : tap_addr_pattern
`default_nettype wire

// >>> test/tap_checker.sv
// Port-level assertions for the address-pattern block
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"

module tap_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`TAP_PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic wr_issue,
	input wire logic rd_issue,
	input wire logic loop_start,
	input wire logic [`TAP_WADDR_W-1:0] word_addr,
	input wire logic [`TAP_SADDR_W-1:0] symbol_addr,
	input wire logic addr_valid,
	input wire logic addr_is_read,
	input wire logic irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ********
	// APB handshake
	// ********
	sequence apb_setup;
		psel && !penable && clk_en;
	endsequence
	sequence apb_access;
		apb_setup ##1 (psel && penable && clk_en);
	endsequence
	chk_apb_wait: assert property (apb_setup |=> !pready) else $error("no wait state");
	chk_apb_answer: assert property (apb_access |=> pready) else $error("late pready");
	chk_slverr_pair: assert property (pslverr |-> pready) else $error("lone pslverr");
	chk_unaligned_err: assert property (pready && (paddr[1:0] != 2'h0) |-> pslverr)
		else $error("unaligned accepted");
	chk_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("write data echoed");

	// ********
	// Address issue
	// ********
	// An issue is only taken while the clock enable is high
	logic issue;
	assign issue = clk_en && (wr_issue || rd_issue);
	chk_valid_after: assert property (issue |=> addr_valid) else $error("issue lost");
	chk_valid_cause: assert property (addr_valid |-> $past(issue)) else $error("stray valid");
	chk_read_flag: assert property (addr_valid |-> addr_is_read == $past(rd_issue && !wr_issue))
		else $error("wrong direction");
	chk_addr_hold: assert property (!addr_valid |-> $stable(word_addr) && $stable(addr_is_read))
		else $error("address moved");
	chk_symbol_shift: assert property (symbol_addr == {word_addr, 5'h00})
		else $error("symbol address");
endmodule : tap_checker
`default_nettype wire

// >>> test/tap_mem_model.sv
// Memory command port model that checks read addresses replay the writes
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"

module tap_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic addr_valid,
	input wire logic addr_is_read,
	input wire logic [`TAP_WADDR_W-1:0] word_addr,
	output int order_errs
);
	logic [`TAP_WADDR_W-1:0] wq[$];

	// Reads must find the data where the writes left it, so order matters
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wq.delete();
			order_errs <= 0;
		end else if (addr_valid && !addr_is_read) begin
			wq.push_back(word_addr);
		end else if (addr_valid && wq.size() > 0) begin
			if (wq.pop_front() !== word_addr) order_errs <= order_errs + 1;
		end
	end
endmodule : tap_mem_model
`default_nettype wire

// >>> test/tap_addr_pattern_bench.sv
// Self-checking bench of the address-pattern block
`timescale 1ns/1ps
`default_nettype none
`include "tap_regs.svh"
`define CHK(nm, e, g) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("CHECK FAILED %s exp %0h got %0h", nm, (e), (g)); \
	end \
end

module tap_addr_pattern_bench;
	logic pclk, presetn, clk_en, psel, penable, pwrite, wr_issue, rd_issue, loop_start;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, addr_valid, addr_is_read, irq;
	logic [25:0] word_addr, got;
	logic [30:0] symbol_addr;
	logic [15:0] seen;
	int fail_count, samples_checked, order_errs;

	tap_addr_pattern DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wr_issue(wr_issue), .rd_issue(rd_issue),
		.loop_start(loop_start), .word_addr(word_addr), .symbol_addr(symbol_addr),
		.addr_valid(addr_valid), .addr_is_read(addr_is_read), .irq(irq));
	tap_mem_model u_mem (.pclk(pclk), .presetn(presetn), .addr_valid(addr_valid),
		.addr_is_read(addr_is_read), .word_addr(word_addr), .order_errs(order_errs));

	// ********
	// Bus and issue tasks
	// ********
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wreg
	// Per-field entries sit one word apart
	task automatic fld(input logic [11:0] base, input int n, input logic [31:0] d);
		wreg(base + 12'(4 * n), d);
	endtask : fld
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] ex, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		`CHK(nm, ex, q)
		`CHK(nm, xe, e)
	endtask : rchk
	task automatic issue(input logic rd, output logic [25:0] g);
		@(posedge pclk);
		wr_issue <= !rd;
		rd_issue <= rd;
		@(posedge pclk);
		wr_issue <= 1'b0;
		rd_issue <= 1'b0;
		#1;
		g = word_addr;
	endtask : issue
	task automatic pulse_loop;
		@(posedge pclk);
		loop_start <= 1'b1;
		@(posedge pclk);
		loop_start <= 1'b0;
	endtask : pulse_loop
	task give_verdict;
		if (fail_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	// Clock at 250 MHz
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#100000;
		fail_count++;
		give_verdict();
	end

	// ********
	// Tests
	// ********
	initial begin
		{presetn, clk_en, psel, penable, pwrite, wr_issue, rd_issue, loop_start} = 8'h40;
		paddr = 12'h000;
		pwdata = 32'h0;
		fail_count = 0;
		samples_checked = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rchk("burst rst", `TAP_BURST_OFS, 32'h1, 1'b0);
		rchk("period rst", `TAP_PERIOD_BASE + 12'h014, 32'h1, 1'b0);
		rchk("msb rst", `TAP_MSB_BASE + 12'h010, 32'h19, 1'b0);
		rchk("no msb5", `TAP_MSB_BASE + 12'h014, 32'h0, 1'b1);
		rchk("unmapped", 12'hFFC, 32'h0, 1'b1);
		rchk("unaligned", `TAP_CTRL_OFS + 12'h002, 32'h0, 1'b1);
		// Sequential field 0, reads replay, loop restart on and off
		fld(`TAP_MODE_BASE, 0, 32'h2);
		fld(`TAP_INCR_BASE, 0, 32'h8);
		wreg(`TAP_MASK_OFS, 32'h2);
		wreg(`TAP_CTRL_OFS, 32'h5);
		for (int i = 0; i < 6; i++) begin
			issue(i > 2, got);
			`CHK("seq", 26'(8 * (i % 3)), got)
		end
		// Let the model take the last read before its count is looked at
		repeat (2) @(posedge pclk);
		`CHK("replay", 0, order_errs)
		`CHK("irq set", 1'b1, irq)
		wreg(`TAP_STATUS_OFS, 32'h2);
		rchk("status clr", `TAP_STATUS_OFS, 32'h0, 1'b0);
		`CHK("irq clr", 1'b0, irq)
		// A frozen clock enable swallows the issue
		@(posedge pclk);
		clk_en <= 1'b0;
		wr_issue <= 1'b1;
		@(posedge pclk);
		clk_en <= 1'b1;
		wr_issue <= 1'b0;
		#1;
		`CHK("frozen", 1'b0, addr_valid)
		pulse_loop();
		issue(1'b0, got);
		`CHK("restart", 26'h0, got)
		wreg(`TAP_CTRL_OFS, 32'h0);
		issue(1'b0, got);
		pulse_loop();
		issue(1'b0, got);
		`CHK("no restart", 26'h10, got)
		// Several fields with their own boundaries and update periods
		for (int n = 0; n < 5; n++) fld(`TAP_MSB_BASE, n, n == 4 ? 32'h13 : 32'(3 + 2 * n + (n > 0) * 2));
		rchk("msb1", `TAP_MSB_BASE + 12'h004, 32'h7, 1'b0);
		fld(`TAP_INCR_BASE, 0, 32'h1);
		fld(`TAP_MODE_BASE, 1, 32'h2);
		fld(`TAP_INCR_BASE, 1, 32'h1);
		fld(`TAP_PERIOD_BASE, 1, 32'h2);
		fld(`TAP_WSTART_BASE, 5, 32'h1);
		wreg(`TAP_CTRL_OFS, 32'h4);
		for (int i = 0; i < 4; i++) begin
			issue(1'b0, got);
			`CHK("fields", 26'h100000 | 26'((i / 2) << 4) | 26'(i), got)
		end
		fld(`TAP_MODE_BASE, 5, 32'h3);
		issue(1'b0, got);
		`CHK("unused", 26'h24, got)
		// Random field 0 of four bits walks all fifteen values once
		fld(`TAP_MODE_BASE, 1, 32'h3);
		fld(`TAP_MODE_BASE, 0, 32'h1);
		fld(`TAP_WSTART_BASE, 0, 32'h1);
		wreg(`TAP_CTRL_OFS, 32'h4);
		seen = 16'h0;
		for (int i = 0; i < 15; i++) begin
			issue(1'b0, got);
			if (i == 0) `CHK("rnd start", 26'h1, got)
			`CHK("rnd range", 1'b1, got < 26'hF)
			`CHK("rnd repeat", 1'b0, seen[got[3:0]])
			seen[got[3:0]] = 1'b1;
		end
		// Reserved low bits for burst and half rate, and the narrow-field error
		fld(`TAP_MODE_BASE, 0, 32'h0);
		fld(`TAP_WSTART_BASE, 0, 32'hF);
		wreg(`TAP_BURST_OFS, 32'h3);
		issue(1'b0, got);
		`CHK("burst bits", 26'hC, got)
		wreg(`TAP_CTRL_OFS, 32'h2);
		issue(1'b0, got);
		`CHK("align bits", 26'h8, got)
		wreg(`TAP_STATUS_OFS, 32'h3);
		fld(`TAP_MSB_BASE, 0, 32'h1);
		issue(1'b0, got);
		rchk("width err", `TAP_STATUS_OFS, 32'h3, 1'b0);
		// Fixed mode gives separate write and read values
		fld(`TAP_MSB_BASE, 0, 32'h19);
		wreg(`TAP_CTRL_OFS, 32'h0);
		wreg(`TAP_BURST_OFS, 32'h1);
		fld(`TAP_WSTART_BASE, 0, 32'h123);
		fld(`TAP_RSTART_BASE, 0, 32'h456);
		issue(1'b0, got);
		`CHK("fixed wr", 26'h123, got)
		issue(1'b1, got);
		`CHK("fixed rd", 26'h456, got)
		`CHK("read dir", 1'b1, addr_is_read)
		`CHK("symbol", 31'h00008AC0, symbol_addr)
		rchk("addr reg", `TAP_ADDR_OFS, 32'h00000456, 1'b0);
		give_verdict();
	end
endmodule : tap_addr_pattern_bench

bind tap_addr_pattern tap_checker u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .wr_issue(wr_issue),
	.rd_issue(rd_issue), .loop_start(loop_start), .word_addr(word_addr),
	.symbol_addr(symbol_addr), .addr_valid(addr_valid), .addr_is_read(addr_is_read), .irq(irq));
`default_nettype wire
